// file: logic/tag_jump_exec.sv
/*
  Executes one instruction per exec_i pulse: tag load, buffer address loads,
  conditional jumps, end-around shift and add immediate.
  Assumes fetch logic presents both instruction words and samples next_pc_o.
*/
`timescale 1ns/1ps
module tag_jump_exec (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        exec_i,
  input  wire logic [7:0]  word1_i,
  input  wire logic [7:0]  word2_i,
  input  wire logic [11:0] pc_i,
  input  wire logic        buffer_busy_i,
  output logic [7:0]       acc_o,
  output logic [15:0]      tags_o,
  output logic [9:0]       buffer_entrance_address_o,
  output logic [9:0]       buffer_exit_address_o,
  output logic [11:0]      buffer_start_address_o,
  output logic [11:0]      next_pc_o,
  output logic             done_o
);
  logic [7:0]  acc_r;
  logic [7:0]  acc_nxt;
  logic [3:0]  tag_r [4];
  logic [9:0]  ber_r;
  logic [9:0]  bxr_r;
  logic [11:0] npc_r;
  logic [11:0] npc_nxt;
  logic        done_r;
  logic [9:0]  bxr_src;

  // Busy is a pin from the buffer channel: three stages, change needs agreement
  logic [2:0]  busy_sync_r;
  logic        busy_r;

  wire [5:0]  op       = word1_i[tag_jump_pkg::OP_MSB:0];
  wire [1:0]  tag_sel  = word1_i[tag_jump_pkg::TAG_SEL_MSB:tag_jump_pkg::TAG_SEL_LSB];
  wire [3:0]  tag_val  = (tag_sel == 2'h0) ? tag_jump_pkg::TAG_RST : tag_r[tag_sel];
  wire [11:0] jump_adr = {tag_val, word2_i};
  wire [11:0] pc_p1    = pc_i + 12'h001;
  wire [11:0] pc_p2    = pc_i + 12'h002;
  wire        acc_zero = (acc_r == 8'h00);
  wire        acc_neg  = acc_r[tag_jump_pkg::SIGN_BIT];
  wire [8:0]  raw_sum  = {1'b0, acc_r} + {1'b0, word2_i};
  wire [7:0]  oc_sum   = raw_sum[7:0] + {7'h00, raw_sum[8]};
  wire [9:0]  buf_src  = {tag_r[tag_jump_pkg::BUF_TAG][1:0], acc_r};
  wire        buf_jump = busy_r ? 1'b1 : 1'b0;

  // Both buffer loads share one branch, so a single decode serves every check of it
  function automatic logic is_buf_load(input logic [5:0] code);
    is_buf_load = (code == tag_jump_pkg::OP_BUF_ENTRANCE) || (code == tag_jump_pkg::OP_BUF_EXIT);
  endfunction : is_buf_load

  always_comb begin
    acc_nxt = acc_r;
    npc_nxt = pc_p1;
    unique case (op)
      tag_jump_pkg::OP_BUF_ENTRANCE,
      tag_jump_pkg::OP_BUF_EXIT:     npc_nxt = buf_jump ? jump_adr : pc_p2;
      tag_jump_pkg::OP_JUMP_ZERO:    npc_nxt = acc_zero ? jump_adr : pc_p2;
      tag_jump_pkg::OP_JUMP_NONZERO: npc_nxt = !acc_zero ? jump_adr : pc_p2;
      tag_jump_pkg::OP_JUMP_POS:     npc_nxt = !acc_neg ? jump_adr : pc_p2;
      tag_jump_pkg::OP_JUMP_NEG:     npc_nxt = acc_neg ? jump_adr : pc_p2;
      tag_jump_pkg::OP_SHIFT:        acc_nxt = {acc_r[6:0], acc_r[7]};
      tag_jump_pkg::OP_ADD_IMM: begin
        acc_nxt = oc_sum;
        npc_nxt = pc_p2;
      end
      default:                       npc_nxt = pc_p1;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_sync_r <= 3'h0;
      busy_r      <= 1'b0;
    end else begin
      busy_sync_r <= {busy_sync_r[1:0], buffer_busy_i};
      if (busy_sync_r[1] == busy_sync_r[2]) begin
        busy_r <= busy_sync_r[2];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_r  <= tag_jump_pkg::ACC_RST;
      ber_r  <= tag_jump_pkg::BUF_RST;
      bxr_r  <= tag_jump_pkg::BUF_RST;
      npc_r  <= tag_jump_pkg::PC_RST;
      done_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        tag_r[i] <= tag_jump_pkg::TAG_RST;
      end
    end else begin
      done_r <= exec_i;
      if (exec_i) begin
        acc_r <= acc_nxt;
        npc_r <= npc_nxt;
        if (op == tag_jump_pkg::OP_ACC_TO_TAG) begin
          tag_r[tag_sel] <= acc_r[3:0];
        end
        if (op == tag_jump_pkg::OP_BUF_ENTRANCE) begin
          ber_r <= buf_src;
        end
        if (op == tag_jump_pkg::OP_BUF_EXIT) begin
          bxr_r <= buf_src;
        end
      end
    end
  end

  // Only the entrance register forms the start address; the exit one leaves as loaded
  assign bxr_src = bxr_r;
  assign buffer_start_address_o    = {tag_r[tag_jump_pkg::BUF_TAG][3:2], ber_r};
  assign acc_o                     = acc_r;
  assign tags_o                    = {tag_r[3], tag_r[2], tag_r[1], tag_r[0]};
  assign buffer_entrance_address_o = ber_r;
  assign buffer_exit_address_o     = bxr_src;
  assign next_pc_o                 = npc_r;
  assign done_o                    = done_r;

  AST_TAG_COPY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_ACC_TO_TAG && tag_sel != 2'h0 |=>
      tag_r[$past(tag_sel)] == $past(acc_r[3:0]) && npc_r == $past(pc_i) + 12'h001)
    else $error("tag copy wrong");
  AST_BER_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_BUF_ENTRANCE |=> ber_r == {$past(tag_r[3][1:0]), $past(acc_r)})
    else $error("entrance load wrong");
  AST_BXR_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_BUF_EXIT |=> bxr_r == {$past(tag_r[3][1:0]), $past(acc_r)})
    else $error("exit load wrong");
  // Busy is judged after the synchroniser, so the branch trails the pin by a few cycles
  sequence s_buf_load_busy;
    exec_i && busy_r && is_buf_load(op);
  endsequence
  sequence s_buf_load_idle;
    exec_i && !busy_r && is_buf_load(op);
  endsequence

  AST_BUF_BUSY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_buf_load_busy |=> npc_r == $past(jump_adr))
    else $error("busy branch wrong");
  AST_BUF_IDLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_buf_load_idle |=> npc_r == $past(pc_i) + 12'h002)
    else $error("idle continue wrong");
  AST_ZERO_JUMP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_JUMP_ZERO |=>
      npc_r == (($past(acc_r) == 8'h00) ? $past(jump_adr) : $past(pc_i) + 12'h002))
    else $error("zero jump wrong");
  AST_MINUS_ZERO: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_JUMP_ZERO && acc_r == 8'hff |=> npc_r == $past(pc_i) + 12'h002)
    else $error("minus zero taken");
  AST_SIGN_JUMP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_JUMP_NEG && acc_r[7] |=> npc_r == $past(jump_adr))
    else $error("negative jump wrong");
  AST_ROTATE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_SHIFT |=> acc_r == {$past(acc_r[6:0]), $past(acc_r[7])})
    else $error("rotate wrong");
  AST_ADD_IMM: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_ADD_IMM && acc_r == 8'hfe && word2_i == 8'h02 |=> acc_r == 8'h01)
    else $error("add end-around wrong");

  // Nonzero and positive jumps recompute the branch from the accumulator as it stood at execution; the rest fix one outcome
  AST_NONZERO_JUMP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_JUMP_NONZERO |=>
      npc_r == (($past(acc_r) != 8'h00) ? $past(jump_adr) : $past(pc_i) + 12'h002))
    else $error("nonzero jump wrong");
  AST_POS_JUMP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_JUMP_POS |=>
      npc_r == ($past(acc_r[7]) ? $past(pc_i) + 12'h002 : $past(jump_adr)))
    else $error("positive jump wrong");
  AST_NEG_FALL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_JUMP_NEG && !acc_r[7] |=> npc_r == $past(pc_i) + 12'h002)
    else $error("negative fall through wrong");
  AST_SEL_ZERO: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_JUMP_NONZERO && tag_sel == 2'h0 && acc_r != 8'h00
      |=> npc_r == {4'h0, $past(word2_i)})
    else $error("designation zero upper bits wrong");

  // Buffer registers: each load touches only its own register
  AST_START_ADDR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_BUF_ENTRANCE |=>
      buffer_start_address_o == {$past(tag_r[3]), $past(acc_r)})
    else $error("start address wrong");
  AST_BXR_KEEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_BUF_ENTRANCE |=> $stable(bxr_r))
    else $error("entrance load changed exit register");
  AST_BER_KEEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_BUF_EXIT |=> $stable(ber_r))
    else $error("exit load changed entrance register");

  AST_ACC_KEEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_ACC_TO_TAG |=> $stable(acc_r))
    else $error("tag copy changed accumulator");
  AST_TAG_KEEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_ACC_TO_TAG && tag_sel == 2'h2 |=>
      $stable(tag_r[3]) && $stable(tag_r[1]) && $stable(tag_r[0]))
    else $error("unselected tag changed");
  AST_ROTATE_NEXT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_SHIFT |=> npc_r == $past(pc_i) + 12'h001)
    else $error("rotate next address wrong");
  AST_ADD_NEXT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_ADD_IMM |=> npc_r == $past(pc_i) + 12'h002)
    else $error("add next address wrong");
  AST_MINUS_ZERO_SUM: assert property (@(posedge clk_i) disable iff (!nrst_i)
    exec_i && op == tag_jump_pkg::OP_ADD_IMM && acc_r == 8'hff && word2_i == 8'hff |=> acc_r == 8'hff)
    else $error("minus zero sum wrong");
endmodule : tag_jump_exec

// file: logic/tag_jump_pkg.sv
/*
  Constants for the accumulator, tag, buffer-address and conditional jump
  execution block. Assumes a 12-bit core address and an 8-bit word.
*/
package tag_jump_pkg;
  localparam int unsigned ACC_W       = 8;
  localparam int unsigned TAG_W       = 4;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned BUF_W       = 10;
  localparam int unsigned TAG_SEL_MSB = 7;
  localparam int unsigned TAG_SEL_LSB = 6;
  localparam int unsigned OP_MSB      = 5;
  localparam int unsigned BUF_TAG     = 3;
  localparam int unsigned SIGN_BIT    = 7;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [3:0]  TAG_RST     = 4'h0;
  localparam logic [9:0]  BUF_RST     = 10'h000;
  localparam logic [11:0] PC_RST      = 12'h000;

  typedef enum logic [5:0] {
    OP_ACC_TO_TAG   = 6'h00,
    OP_BUF_ENTRANCE = 6'h04,
    OP_BUF_EXIT     = 6'h05,
    OP_JUMP_ZERO    = 6'h10,
    OP_JUMP_NONZERO = 6'h11,
    OP_JUMP_POS     = 6'h12,
    OP_JUMP_NEG     = 6'h13,
    OP_SHIFT        = 6'h0f,
    OP_ADD_IMM      = 6'h30
  } opcode_t;
endpackage : tag_jump_pkg

// file: verification/accumulator_tag_jump_execute_tb.sv
/* Bench for the tag, buffer-address, jump, shift and add block.
   Assumes one exec pulse per instruction and a 100 ns clock. */
`timescale 1ns/1ps
module accumulator_tag_jump_execute_tb;
  logic        clk_i = 1'b0, nrst_i = 1'b0, exec = 1'b0, busy_req = 1'b0, busy;
  logic [7:0]  w1 = 8'h00, w2 = 8'h00, acc, a = 8'h00;
  logic [11:0] pc = 12'h000, start, npc;
  logic [15:0] tags;
  logic [9:0]  ent, ext;
  logic        done;
  int          n_mismatch = 0, samples_checked = 0;
  always #50 clk_i = ~clk_i;
  buffer_channel_model buffer_channel_model_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .busy_req_i(busy_req), .busy_o(busy));
  tag_jump_exec tag_jump_exec_inst (.clk_i(clk_i), .nrst_i(nrst_i), .exec_i(exec),
    .word1_i(w1), .word2_i(w2), .pc_i(pc), .buffer_busy_i(busy), .acc_o(acc),
    .tags_o(tags), .buffer_entrance_address_o(ent), .buffer_exit_address_o(ext),
    .buffer_start_address_o(start), .next_pc_o(npc), .done_o(done));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One idle cycle between operations keeps exec from being driven twice at once
  task op(input logic [7:0] b1, b2, input logic [11:0] p, input logic [7:0] ea,
          input logic [11:0] ep);
    @(negedge clk_i);
    chk("done_idle", 16'h0000, {15'h0000, done});
    exec = 1'b1; w1 = b1; w2 = b2; pc = p;
    @(negedge clk_i);
    exec = 1'b0;
    a = ea;
    chk("done", 16'h0001, {15'h0000, done});
    chk("acc", {8'h00, ea}, {8'h00, acc});
    chk("next_pc", {4'h0, ep}, {4'h0, npc});
  endtask : op
  task jset(input logic [11:0] p, input logic s);
    logic tk;
    for (int k = 0; k < 4; k++) begin
      tk = (k == 0) ? (a == 8'h00) : (k == 1) ? (a != 8'h00) : (k == 2) ? !a[7] : a[7];
      op({s, 1'b0, 6'h10 + 6'(k)}, 8'h11, p, a, tk ? (s ? 12'h911 : 12'h011) : p + 12'h002);
    end
  endtask : jset
  task t_zero;
    jset(12'h0f0, 1'b0);
    $display("test zero done");
  endtask : t_zero
  task t_add_tag;
    op(8'h30, 8'h75, 12'h0fe, 8'h75, 12'h100);
    op(8'hc0, 8'h00, 12'h100, 8'h75, 12'h101);
    op(8'h30, 8'h04, 12'h101, 8'h79, 12'h103);
    op(8'h80, 8'h00, 12'h103, 8'h79, 12'h104);
    op(8'h30, 8'hff, 12'h104, 8'h79, 12'h106);
    chk("tags", 16'h5900, tags);
    $display("test add_tag done");
  endtask : t_add_tag
  task t_buffer;
    op(8'h84, 8'h3c, 12'h200, 8'h79, 12'h202);
    chk("entrance", 16'h0179, {6'h00, ent});
    chk("start", 16'h0579, {4'h0, start});
    busy_req = 1'b1;
    // Busy passes a synchroniser, so let it settle first
    repeat (8) @(negedge clk_i);
    op(8'h85, 8'h3c, 12'h210, 8'h79, 12'h93c);
    chk("exit", 16'h0179, {6'h00, ext});
    busy_req = 1'b0;
    repeat (8) @(negedge clk_i);
    $display("test buffer done");
  endtask : t_buffer
  task t_jumps;
    jset(12'h300, 1'b1);
    op(8'h0f, 8'h00, 12'h310, 8'hf2, 12'h311);
    jset(12'h320, 1'b1);
    op(8'h30, 8'h0d, 12'h330, 8'hff, 12'h332);
    jset(12'h340, 1'b1);
    $display("test jumps done");
  endtask : t_jumps
  task t_edges;
    op(8'h30, 8'hff, 12'h400, 8'hff, 12'h402);
    op(8'h30, 8'hfe, 12'h402, 8'hfe, 12'h404);
    op(8'h30, 8'h02, 12'h404, 8'h01, 12'h406);
    op(8'h00, 8'h00, 12'h406, 8'h01, 12'h407);
    chk("tags", 16'h5901, tags);
    op(8'h11, 8'h6a, 12'h407, 8'h01, 12'h06a);
    op(8'h45, 8'h00, 12'h408, 8'h01, 12'h40a);
    chk("exit", 16'h0101, {6'h00, ext});
    chk("entrance", 16'h0179, {6'h00, ent});
    $display("test edges done");
  endtask : t_edges
  task t_reset;
    @(negedge clk_i);
    nrst_i = 1'b0;
    @(negedge clk_i);
    chk("rst_acc", 16'h0000, {8'h00, acc});
    chk("rst_tags", 16'h0000, tags);
    chk("rst_entrance", 16'h0000, {6'h00, ent});
    chk("rst_exit", 16'h0000, {6'h00, ext});
    chk("rst_start", 16'h0000, {4'h0, start});
    chk("rst_next_pc", 16'h0000, {4'h0, npc});
    chk("rst_done", 16'h0000, {15'h0000, done});
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    a = 8'h00;
    repeat (4) @(negedge clk_i);
    op(8'h10, 8'h22, 12'h100, 8'h00, 12'h022);
    $display("test reset done");
  endtask : t_reset
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (16) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_zero();
    t_add_tag();
    t_buffer();
    t_jumps();
    t_edges();
    t_reset();
    wrap_up();
  end
endmodule : accumulator_tag_jump_execute_tb

// file: verification/buffer_channel_model.sv
/* Buffer channel stand-in: reports busy as a level on request.
   Assumes the bench asks for busy away from the rising edge. */
`timescale 1ns/1ps
module buffer_channel_model (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic busy_req_i,
  output logic      busy_o
);
  // Registered so busy never glitches inside a cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) busy_o <= 1'b0;
    else busy_o <= busy_req_i;
  end
endmodule : buffer_channel_model
